// ==== design/cfm_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the configuration array map
// Assumes: Word addressed APB registers, byte address is four times the index
// Notes: Definitions only
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH

// ****************************************
// Register indices
// ****************************************
`define CFM_NUM_BYTES 13
`define CFM_IDX_OPTIONS0 4'h0
`define CFM_IDX_OPTIONS1 4'h1
`define CFM_IDX_CODING_AND_TIMEBASE_BYTE 4'h2
`define CFM_IDX_DELAY_AND_RF_PRESCALE_BYTE 4'h3
`define CFM_IDX_RF_AND_IR_PRESCALE_BYTE 4'h4
`define CFM_IDX_INITIAL_ROLLING_CODE 4'h5
`define CFM_IDX_KEY_IDENTITY_VALUE 4'h8
`define CFM_IDX_SYNC_FIELD_VALUE 4'hb
`define CFM_IDX_FACTORY_RESERVED_BYTE 4'hc
`define CFM_IDX_CONTROL 6'h10
`define CFM_IDX_STATUS 6'h11

// ****************************************
// Field positions
// ****************************************
`define CFM_BIT_HOLD_TIMEOUT_EN 4
`define CFM_BIT_DISABLE_HI 1
`define CFM_BIT_DISABLE_LO 0
`define CFM_BIT_LOW_BATT_DETECT_EN 0
`define CFM_BIT_CODING_FAMILY_SEL 7
`define CFM_MSB_CODING_VARIANT_SEL 6
`define CFM_LSB_CODING_VARIANT_SEL 4
`define CFM_BIT_TRANSMIT_POLARITY 3
`define CFM_BIT_BIT_CLOCK_SEL 2
`define CFM_CTRL_BIT_START 0
`define CFM_CTRL_BIT_STOP 1
`define CFM_STAT_BIT_OPERATING 0
`define CFM_STAT_BIT_DISABLED 1
`define CFM_STAT_BIT_LOAD_DONE 2
`define CFM_STAT_BIT_TX_INHIBIT 3
`define CFM_FORMATS_PER_FAMILY 3'h6
`define CFM_NUM_FORMATS 4'hc

// ****************************************
// Reset values and timing
// ****************************************
`define CFM_BYTE_RESET 8'h00
`define CFM_STREAM_BITS 7'h68
`define CFM_HOLD_TIMEOUT_S 64'd80
`define CFM_PCLK_HZ 64'd250000000

`endif

// ==== design/cfm_pkg.sv ====
// Purpose: Types of the configuration array map
// Assumes: Thirteen byte array
// Notes: Widths fixed by the array layout
package cfm_pkg;

  typedef logic [12:0][7:0] cfm_array_type;

  typedef struct packed {
    logic [2:0] sync_clk;
    logic [2:0] sync_dat;
    logic [2:0] sync_en;
    logic filt_clk;
    logic filt_dat;
    logic filt_en;
    logic [6:0] count;
    logic bit_valid;
    logic [3:0] bit_index;
    logic [2:0] bit_pos;
    logic bit_val;
    logic done;
  } cfm_loader_type;

  typedef struct packed {
    cfm_array_type cfg;
    logic operating;
    logic disabled;
    logic load_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic low_batt_detect_en;
    logic coding_family_sel;
    logic [2:0] coding_variant_sel;
    logic [3:0] bit_coding_format;
    logic format_valid;
    logic transmit_polarity;
    logic bit_clock_sel;
    logic [5:0] delay_prescale;
    logic [5:0] rf_clock_prescale;
    logic [5:0] ir_clock_prescale;
    logic [23:0] initial_rolling_code;
    logic [23:0] key_identity_value;
    logic [7:0] sync_field_value;
    logic hold_timeout_en;
    logic tx_out;
    logic bit_tick;
    logic [2:0] key_sync;
    logic key_held;
    logic [35:0] hold_cnt;
    logic tx_inhibit;
  } cfm_core_type;

endpackage : cfm_pkg

// ==== design/cfm_serial_loader.sv ====
// Purpose: Turns the serial programming stream into single bit writes of the array
// Assumes: Programming pins are asynchronous to pclk
// Notes: Each pin passes three flip-flops, a change counts when stages two and three agree
`timescale 1ns/1ns
`include "cfm_regs.svh"

module cfm_serial_loader (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Programming pins
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic prog_en,
  // Bit write towards the array
  output logic bit_valid,
  output logic [3:0] bit_index,
  output logic [2:0] bit_pos,
  output logic bit_val,
  output logic done
);
  import cfm_pkg::*;

  cfm_loader_type r;
  cfm_loader_type next_r;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.bit_valid = 1'b0;
    next_r.done = 1'b0;
    next_r.sync_clk = {r.sync_clk[1:0], prog_clk};
    next_r.sync_dat = {r.sync_dat[1:0], prog_data};
    next_r.sync_en = {r.sync_en[1:0], prog_en};
    if (r.sync_clk[1] == r.sync_clk[2]) begin
      next_r.filt_clk = r.sync_clk[2];
    end
    if (r.sync_dat[1] == r.sync_dat[2]) begin
      next_r.filt_dat = r.sync_dat[2];
    end
    if (r.sync_en[1] == r.sync_en[2]) begin
      next_r.filt_en = r.sync_en[2];
    end
    if (!r.filt_en) begin
      next_r.count = 7'h00;
    end else if (next_r.filt_clk && !r.filt_clk && r.count < `CFM_STREAM_BITS) begin
      // first bit lands at MSB of byte 0
      next_r.bit_valid = 1'b1;
      next_r.bit_index = r.count[6:3];
      next_r.bit_pos = 3'h7 - r.count[2:0];
      next_r.bit_val = next_r.filt_dat;
      next_r.count = r.count + 7'h01;
      next_r.done = (r.count == `CFM_STREAM_BITS - 7'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bit_valid = r.bit_valid;
  assign bit_index = r.bit_index;
  assign bit_pos = r.bit_pos;
  assign bit_val = r.bit_val;
  assign done = r.done;

endmodule : cfm_serial_loader

// ==== design/cfm_config_map.sv ====
// Purpose: Configuration array of the rolling-code encoder, its APB access and its decoded settings
// Assumes: APB master as published, zero wait from the master side
// Notes: Decoded settings latch on start and stay constant while operating
`timescale 1ns/1ns
`include "cfm_regs.svh"

module cfm_config_map #(
  parameter logic [35:0] HOLD_TIMEOUT_CYCLES = 36'(`CFM_HOLD_TIMEOUT_S * `CFM_PCLK_HZ)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial programming pins
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic prog_en,
  // Transmit path
  input wire logic key_pin,
  input wire logic tx_active,
  input wire logic tx_data,
  input wire logic ir_tick,
  input wire logic rf_tick,
  output logic tx_out,
  output logic bit_tick,
  // Decoded settings
  output logic operating,
  output logic chip_disabled,
  output logic low_batt_detect_en,
  output logic coding_family_sel,
  output logic [2:0] coding_variant_sel,
  output logic [3:0] bit_coding_format,
  output logic format_valid,
  output logic transmit_polarity,
  output logic bit_clock_sel,
  output logic [5:0] delay_prescale,
  output logic [5:0] rf_clock_prescale,
  output logic [5:0] ir_clock_prescale,
  output logic [23:0] initial_rolling_code,
  output logic [23:0] key_identity_value,
  output logic [7:0] sync_field_value,
  output logic hold_timeout_en,
  output logic tx_inhibit
);
  import cfm_pkg::*;

  // State
  cfm_core_type r;
  cfm_core_type next_r;
  // Loader bit write
  logic ld_valid;
  logic [3:0] ld_index;
  logic [2:0] ld_pos;
  logic ld_val;
  logic ld_done;

  // ****************************************
  // Serial loader
  // ****************************************
  cfm_serial_loader u_loader (
    .pclk(pclk),
    .presetn(presetn),
    .prog_clk(prog_clk),
    .prog_data(prog_data),
    .prog_en(prog_en),
    .bit_valid(ld_valid),
    .bit_index(ld_index),
    .bit_pos(ld_pos),
    .bit_val(ld_val),
    .done(ld_done)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic index_is_byte(input logic [5:0] idx);
    index_is_byte = (idx < 6'(`CFM_NUM_BYTES));
  endfunction : index_is_byte

  function automatic logic [4:0] coding_format(input logic family, input logic [2:0] variant);
    logic [3:0] fmt;
    logic ok;
    fmt = {1'b0, variant};
    ok = (variant < `CFM_FORMATS_PER_FAMILY);
    if (!family) begin
      fmt = {1'b0, variant} + {1'b0, `CFM_FORMATS_PER_FAMILY};
    end
    coding_format = {ok, fmt};
  endfunction : coding_format

  function automatic logic [23:0] field24(input cfm_array_type a, input logic [3:0] first);
    field24 = {a[first], a[first + 4'h1], a[first + 4'h2]};
  endfunction : field24

  function automatic logic [31:0] status_word(input logic op, input logic dis, input logic ld, input logic inh);
    status_word = 32'h00000000;
    status_word[`CFM_STAT_BIT_OPERATING] = op;
    status_word[`CFM_STAT_BIT_DISABLED] = dis;
    status_word[`CFM_STAT_BIT_LOAD_DONE] = ld;
    status_word[`CFM_STAT_BIT_TX_INHIBIT] = inh;
  endfunction : status_word

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [5:0] idx;
    logic setup;
    logic access;
    logic [4:0] fmt;
    cfm_array_type c;
    logic wr_ok;

    idx = paddr[7:2];
    setup = psel && !penable;
    access = psel && penable && r.pready;
    wr_ok = access && pwrite && !r.pslverr;
    fmt = 5'h00;
    c = r.cfg;
    next_r = r;
    next_r.pready = 1'b0;

    // ****************************************
    // APB setup: answer prepared for the first access cycle
    // ****************************************
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h00000000;
      if (paddr[1:0] != 2'h0) begin
        next_r.pslverr = 1'b1;
      end else if (index_is_byte(idx)) begin
        // reserved byte reads back, feeds no setting
        next_r.prdata = {24'h000000, r.cfg[idx[3:0]]};
        next_r.pslverr = pwrite && (r.operating || r.disabled);
      end else if (idx == `CFM_IDX_STATUS) begin
        next_r.prdata = status_word(r.operating, r.disabled, r.load_done, r.tx_inhibit);
        next_r.pslverr = pwrite;
      end else if (idx != `CFM_IDX_CONTROL) begin
        next_r.pslverr = 1'b1;
      end
    end

    // ****************************************
    // Array writes, refused while operating or disabled
    // ****************************************
    if (wr_ok && index_is_byte(idx)) begin
      next_r.cfg[idx[3:0]] = pwdata[7:0];
    end
    // serial bit stored at its own position
    if (ld_valid && !r.operating && !r.disabled) begin
      next_r.cfg[ld_index][ld_pos] = ld_val;
    end
    // Load done: set after the last bit, cleared by a new stream
    if (ld_done) begin
      next_r.load_done = 1'b1;
    end
    if (ld_valid && ld_index == 4'h0 && ld_pos == 3'h7) begin
      next_r.load_done = 1'b0;
    end

    // ****************************************
    // Control: start decodes the array, stop returns to programming
    // ****************************************
    if (wr_ok && idx == `CFM_IDX_CONTROL) begin
      if (pwdata[`CFM_CTRL_BIT_STOP]) begin
        next_r.operating = 1'b0;
      end else if (pwdata[`CFM_CTRL_BIT_START] && !r.operating && !r.disabled) begin
        // both disable bits set kill the chip at this power-up
        if (c[`CFM_IDX_OPTIONS0][`CFM_BIT_DISABLE_HI] &&
            c[`CFM_IDX_OPTIONS0][`CFM_BIT_DISABLE_LO]) begin
          next_r.disabled = 1'b1;
        end else begin
          next_r.operating = 1'b1;
          next_r.low_batt_detect_en = c[`CFM_IDX_OPTIONS1][`CFM_BIT_LOW_BATT_DETECT_EN];
          next_r.coding_family_sel = c[`CFM_IDX_CODING_AND_TIMEBASE_BYTE][`CFM_BIT_CODING_FAMILY_SEL];
          next_r.coding_variant_sel =
            c[`CFM_IDX_CODING_AND_TIMEBASE_BYTE][`CFM_MSB_CODING_VARIANT_SEL:`CFM_LSB_CODING_VARIANT_SEL];
          fmt = coding_format(next_r.coding_family_sel, next_r.coding_variant_sel);
          next_r.bit_coding_format = fmt[3:0];
          next_r.format_valid = fmt[4];
          next_r.transmit_polarity = c[`CFM_IDX_CODING_AND_TIMEBASE_BYTE][`CFM_BIT_TRANSMIT_POLARITY];
          next_r.bit_clock_sel = c[`CFM_IDX_CODING_AND_TIMEBASE_BYTE][`CFM_BIT_BIT_CLOCK_SEL];
          next_r.delay_prescale =
            {c[`CFM_IDX_CODING_AND_TIMEBASE_BYTE][1:0], c[`CFM_IDX_DELAY_AND_RF_PRESCALE_BYTE][7:4]};
          next_r.rf_clock_prescale =
            {c[`CFM_IDX_DELAY_AND_RF_PRESCALE_BYTE][3:0], c[`CFM_IDX_RF_AND_IR_PRESCALE_BYTE][7:6]};
          next_r.ir_clock_prescale = c[`CFM_IDX_RF_AND_IR_PRESCALE_BYTE][5:0];
          next_r.initial_rolling_code = field24(c, `CFM_IDX_INITIAL_ROLLING_CODE);
          next_r.key_identity_value = field24(c, `CFM_IDX_KEY_IDENTITY_VALUE);
          next_r.sync_field_value = c[`CFM_IDX_SYNC_FIELD_VALUE];
          next_r.hold_timeout_en = c[`CFM_IDX_OPTIONS0][`CFM_BIT_HOLD_TIMEOUT_EN];
        end
      end
    end

    // ****************************************
    // Key pin: three stages, change counts when the last two agree
    // ****************************************
    next_r.key_sync = {r.key_sync[1:0], key_pin};
    if (r.key_sync[1] == r.key_sync[2]) begin
      next_r.key_held = r.key_sync[2];
    end
    // key held past the timeout inhibits transmission
    if (!r.key_held || !r.operating) begin
      next_r.hold_cnt = 36'h000000000;
      next_r.tx_inhibit = 1'b0;
    end else if (r.hold_cnt < HOLD_TIMEOUT_CYCLES) begin
      next_r.hold_cnt = r.hold_cnt + 36'h000000001;
    end else if (r.hold_timeout_en) begin
      next_r.tx_inhibit = 1'b1;
    end

    // ****************************************
    // Transmit path
    // ****************************************
    // idle and data level set by polarity
    next_r.tx_out = ((r.operating && tx_active && !r.tx_inhibit) ? tx_data : 1'b0) ^ r.transmit_polarity;
    // bit time base from IR or RF clock
    next_r.bit_tick = r.operating && (r.bit_clock_sel ? ir_tick : rf_tick);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // APB answer
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;

  // Transmit path
  assign tx_out = r.tx_out;
  assign bit_tick = r.bit_tick;

  // Decoded settings
  assign operating = r.operating;
  assign chip_disabled = r.disabled;
  assign low_batt_detect_en = r.low_batt_detect_en;
  assign coding_family_sel = r.coding_family_sel;
  assign coding_variant_sel = r.coding_variant_sel;
  assign bit_coding_format = r.bit_coding_format;
  assign format_valid = r.format_valid;
  assign transmit_polarity = r.transmit_polarity;
  assign bit_clock_sel = r.bit_clock_sel;
  assign delay_prescale = r.delay_prescale;
  assign rf_clock_prescale = r.rf_clock_prescale;
  assign ir_clock_prescale = r.ir_clock_prescale;
  assign initial_rolling_code = r.initial_rolling_code;
  assign key_identity_value = r.key_identity_value;
  assign sync_field_value = r.sync_field_value;
  assign hold_timeout_en = r.hold_timeout_en;
  assign tx_inhibit = r.tx_inhibit;

endmodule : cfm_config_map

// ==== verif/cfm_config_map_properties.sv ====
// Purpose: Concurrent checks on the configuration map ports
// Assumes: One pclk domain, reset active low
// Notes: Bound from the bench top file
`timescale 1ns/1ns
module cfm_config_map_properties #(
  parameter logic [35:0] HOLD_TIMEOUT_CYCLES = 36'h14
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Transmit path
  input wire logic tx_active,
  input wire logic tx_data,
  input wire logic ir_tick,
  input wire logic rf_tick,
  input wire logic tx_out,
  input wire logic bit_tick,
  // Settings
  input wire logic operating,
  input wire logic chip_disabled,
  input wire logic coding_family_sel,
  input wire logic [2:0] coding_variant_sel,
  input wire logic [3:0] bit_coding_format,
  input wire logic format_valid,
  input wire logic transmit_polarity,
  input wire logic bit_clock_sel,
  input wire logic [5:0] delay_prescale,
  input wire logic [23:0] initial_rolling_code,
  input wire logic hold_timeout_en,
  input wire logic tx_inhibit
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_array_locked: assert property (setup && pwrite && operating && paddr < 8'h34 |=> pslverr)
    else $error("array write accepted while operating");
  a_fields_hold: assert property (operating && $past(operating) |->
    $stable(delay_prescale) && $stable(initial_rolling_code) && $stable(bit_coding_format))
    else $error("settings changed while operating");
  a_format_map: assert property (operating |-> format_valid == (coding_variant_sel < 3'h6) &&
    bit_coding_format == (coding_family_sel ? {1'b0, coding_variant_sel} : 4'h6 + {1'b0, coding_variant_sel}))
    else $error("coding format mismatch");
  a_tx_level: assert property (1'b1 |=> tx_out ==
    (($past(operating && tx_active && !tx_inhibit) && $past(tx_data)) ^ $past(transmit_polarity)))
    else $error("transmit level mismatch");
  a_tick_select: assert property (1'b1 |=>
    bit_tick == $past(operating && (bit_clock_sel ? ir_tick : rf_tick)))
    else $error("bit tick source mismatch");
  a_disable_sticky: assert property (chip_disabled |=> chip_disabled && !operating)
    else $error("disabled chip left disabled state");
  a_inhibit_cause: assert property ($rose(tx_inhibit) |-> hold_timeout_en && operating)
    else $error("inhibit without timeout enable");
  c_start: cover property ($rose(operating));
  c_inhibit: cover property ($rose(tx_inhibit));
  c_disable: cover property ($rose(chip_disabled));
endmodule : cfm_config_map_properties

// ==== verif/cfm_prog_model.sv ====
// Purpose: External programmer driving the serial configuration pins
// Assumes: Pins pass a three stage synchroniser
// Notes: Four pclk high and five pclk low per bit, clock idles low outside frames
`timescale 1ns/1ns
module cfm_prog_model (
  // Clock
  input wire logic pclk,
  // Programming pins
  output logic prog_clk,
  output logic prog_data,
  output logic prog_en
);
  import cfm_pkg::*;
  initial begin
    prog_clk = 1'b0;
    prog_data = 1'b0;
    prog_en = 1'b0;
  end
  task automatic load(input cfm_pkg::cfm_array_type arr);
    logic b;
    begin
      b = 1'b0;
      @(posedge pclk);
      prog_en <= 1'b1;
      for (int k = 0; k < 104; k++) begin
        b = arr[k / 8][7 - (k % 8)];
        @(posedge pclk);
        prog_data <= b;
        repeat (4) @(posedge pclk);
        prog_clk <= 1'b1;
        repeat (4) @(posedge pclk);
        prog_clk <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      prog_en <= 1'b0;
      prog_data <= ~b;
    end
  endtask : load
endmodule : cfm_prog_model

// ==== verif/test_cfm_config_map.sv ====
// Purpose: Self-checking bench for the configuration map
// Assumes: Hold timeout shortened to 20 cycles
// Notes: Array loaded serially, then checked over APB
`timescale 1ns/1ns
module test_cfm_config_map;
  import cfm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, key_pin, tx_active, tx_data, ir_tick, rf_tick, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire prog_clk, prog_data, prog_en;
  logic tx_out, bit_tick, operating, chip_disabled, low_batt_detect_en, coding_family_sel, format_valid;
  logic transmit_polarity, bit_clock_sel, hold_timeout_en, tx_inhibit;
  logic [2:0] coding_variant_sel;
  logic [3:0] bit_coding_format;
  logic [5:0] delay_prescale, rf_clock_prescale, ir_clock_prescale;
  logic [23:0] initial_rolling_code, key_identity_value;
  logic [7:0] sync_field_value;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  cfm_array_type cfg;
  always #2 pclk = ~pclk;
  cfm_config_map #(.HOLD_TIMEOUT_CYCLES(36'h14)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prog_clk, .prog_data, .prog_en, .key_pin, .tx_active, .tx_data,
    .ir_tick, .rf_tick, .tx_out, .bit_tick, .operating, .chip_disabled, .low_batt_detect_en, .coding_family_sel,
    .coding_variant_sel, .bit_coding_format, .format_valid, .transmit_polarity, .bit_clock_sel, .delay_prescale,
    .rf_clock_prescale, .ir_clock_prescale, .initial_rolling_code, .key_identity_value, .sync_field_value,
    .hold_timeout_en, .tx_inhibit);
  cfm_prog_model prog_u (.pclk, .prog_clk, .prog_data, .prog_en);
  // ****
  // Tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, er}, {31'h0, e});
    if (!w && !e) chk(rd, d);
  endtask : xfer
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    {psel, penable, pwrite, key_pin, tx_active, tx_data, ir_tick, rf_tick} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = {8'h5a, 8'h77, 8'hef, 8'hcd, 8'hab, 8'h56, 8'h34, 8'h12, 8'h9b, 8'h5c, 8'hae, 8'h01, 8'h90};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 8'h44, 32'h0, 0);
    xfer(0, 8'h2c, 32'h0, 0);
    prog_u.load(cfg);
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 13; i++) xfer(0, 8'(4 * i), {24'h0, cfg[i]}, 0);
    xfer(0, 8'h44, 32'h4, 0);
    xfer(0, 8'h34, 32'h0, 1);
    xfer(0, 8'h02, 32'h0, 1);
    xfer(1, 8'h44, 32'h0, 1);
    xfer(1, 8'h40, 32'h1, 0);
    @(posedge pclk);
    chk({31'h0, low_batt_detect_en}, 32'h1);
    chk({28'h0, coding_family_sel, coding_variant_sel}, 32'ha);
    chk({28'h0, bit_coding_format}, 32'h2);
    chk({30'h0, transmit_polarity, bit_clock_sel}, 32'h3);
    chk({14'h0, delay_prescale, rf_clock_prescale, ir_clock_prescale}, {14'h0, 6'h25, 6'h32, 6'h1b});
    chk({8'h0, initial_rolling_code}, 32'h123456);
    chk({8'h0, key_identity_value}, 32'habcdef);
    chk({23'h0, sync_field_value, hold_timeout_en}, {23'h0, 8'h77, 1'b1});
    tx_active <= 1'b1;
    tx_data <= 1'b1;
    ir_tick <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({30'h0, tx_out, bit_tick}, 32'h1);
    tx_data <= 1'b0;
    ir_tick <= 1'b0;
    rf_tick <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({30'h0, tx_out, bit_tick}, 32'h2);
    tx_data <= 1'b1;
    key_pin <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({30'h0, tx_inhibit, tx_out}, 32'h0);
    repeat (28) @(posedge pclk);
    chk({30'h0, tx_inhibit, tx_out}, 32'h3);
    key_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({30'h0, tx_inhibit, tx_out}, 32'h0);
    xfer(1, 8'h08, 32'hff, 1);
    xfer(0, 8'h08, {24'h0, cfg[2]}, 0);
    xfer(1, 8'h40, 32'h2, 0);
    xfer(1, 8'h30, 32'ha5, 0);
    xfer(0, 8'h30, 32'ha5, 0);
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 8; v++) begin
        xfer(1, 8'h08, {24'h0, 1'(f), 3'(v), 4'h2}, 0);
        xfer(1, 8'h40, 32'h1, 0);
        repeat (2) @(posedge pclk);
        chk({26'h0, tx_out, format_valid, bit_coding_format}, {26'h0, 1'b1, 1'(v < 6), f ? 4'(v) : 4'(6 + v)});
        xfer(1, 8'h40, 32'h2, 0);
      end
    end
    xfer(1, 8'h00, 32'h3, 0);
    xfer(1, 8'h40, 32'h1, 0);
    @(posedge pclk);
    chk({30'h0, chip_disabled, operating}, 32'h2);
    xfer(0, 8'h44, 32'h6, 0);
    xfer(1, 8'h00, 32'h0, 1);
    report_and_stop();
  end
endmodule : test_cfm_config_map

bind cfm_config_map cfm_config_map_properties #(.HOLD_TIMEOUT_CYCLES(HOLD_TIMEOUT_CYCLES)) chk_u (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .tx_active, .tx_data, .ir_tick, .rf_tick,
  .tx_out, .bit_tick, .operating, .chip_disabled, .coding_family_sel, .coding_variant_sel, .bit_coding_format,
  .format_valid, .transmit_polarity, .bit_clock_sel, .delay_prescale, .initial_rolling_code, .hold_timeout_en,
  .tx_inhibit);
